// ---- bench/refsched_sva.sv ----
// concurrent checks on one refresh command link
`timescale 1ns/1ps
module refsched_sva
  import refsched_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  input  wire logic       cs_n,
  input  wire logic [3:0] ca,
  input  wire logic [2:0] ba,
  input  wire logic [2:0] aux
);
  logic       is_ref;     // any refresh
  logic       is_pb;      // per-bank refresh
  logic       is_ab;      // all-bank refresh
  logic       is_act;     // activate
  logic       is_blk;     // refresh or activate
  logic [7:0] open_r;     // banks left open
  bank_t      cnt_r;      // shadow bank counter
  bank_t      pb_bank_r;  // bank of last per-bank refresh
  logic [3:0] since_pb_r; // cycles since it, saturating
  assign is_ref = !cs_n && aux == 3'h7 && ca[2:0] == 3'h4;
  assign is_pb  = is_ref && !ca[3];
  assign is_ab  = is_ref && ca[3];
  assign is_act = !cs_n && aux == 3'h0;
  assign is_blk = is_ref || is_act;
  // open map from activates and precharges
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      open_r <= 8'h0;
    end else if (is_act) begin
      open_r[ba] <= 1'b1;
    end else if (!cs_n && aux == 3'h1) begin
      open_r[ba] <= 1'b0;
    end else if (!cs_n && aux == 3'h2) begin
      open_r <= 8'h0;
    end
  end
  // counter zeroed by all-bank, reset and exit commands
  always_ff @(posedge CORE_CLK) begin
    if (RESET || is_ab || (!cs_n && (aux == 3'h3 || aux == 3'h4))) begin
      cnt_r <= 3'h0;
    end else if (is_pb) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end
  // age of the last per-bank refresh
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      since_pb_r <= 4'hf;
      pb_bank_r  <= 3'h0;
    end else if (is_pb) begin
      since_pb_r <= 4'h0;
      pb_bank_r  <= cnt_r;
    end else if (since_pb_r != 4'hf) begin
      since_pb_r <= since_pb_r + 4'h1;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  property p_ref_code;
    (!cs_n && aux == 3'h7) |-> ca[2:0] == 3'h4;
  endproperty
  property p_ab_gap;
    is_ab |=> !is_blk[*8] ##1 !is_blk[*4];
  endproperty
  property p_pb_gap;
    is_pb |=> !is_ref[*5];
  endproperty
  property p_ab_idle;
    is_ab |-> open_r == 8'h0;
  endproperty
  property p_pb_idle;
    is_pb |-> !open_r[cnt_r];
  endproperty
  property p_act_same;
    (is_act && ba == pb_bank_r) |-> since_pb_r >= 4'h5;
  endproperty
  property p_prea_trp;
    (!cs_n && aux == 3'h2) |=> !is_ref;
  endproperty
  property p_pre_trp;
    (!cs_n && aux == 3'h1 && ba == cnt_r) |=> !is_pb;
  endproperty
  a_ref_code: assert property (p_ref_code)
    else $error("refresh code wrong");
  a_ab_gap: assert property (p_ab_gap)
    else $error("command too soon after all-bank refresh");
  a_pb_gap: assert property (p_pb_gap)
    else $error("refresh too soon after per-bank refresh");
  a_ab_idle: assert property (p_ab_idle)
    else $error("all-bank refresh with a bank open");
  a_pb_idle: assert property (p_pb_idle)
    else $error("per-bank refresh of an open bank");
  a_act_same: assert property (p_act_same)
    else $error("activate of refreshed bank too soon");
  a_prea_trp: assert property (p_prea_trp)
    else $error("refresh too soon after precharge all");
  a_pre_trp: assert property (p_pre_trp)
    else $error("per-bank refresh too soon after precharge");
  c_pb: cover property (is_pb);
  c_ab: cover property (is_ab);
  c_act_pb: cover property (is_pb ##[1:8] is_act);
endmodule

// ---- bench/test_lpddr2_refresh_scheduling.sv ----
// self-checking bench for both ends of the refresh link
`timescale 1ns/1ps
module test_lpddr2_refresh_scheduling;
  import refsched_pkg::*;
  logic       clk;       // core clock
  logic       rst;       // sync reset
  logic       act_req;   // shared requests
  bank_t      act_bank;
  logic       pre_req;
  bank_t      pre_bank;
  logic       prea_req;
  logic       srx_req;
  logic       act_done;  // per-bank side outputs
  logic       ref_done;
  logic [7:0] bank_open;
  bank_t      next_bank;
  logic [7:0] bank_idle;
  logic [7:0] bank_busy; // banks under per-bank refresh
  bank_t      dev_cnt;
  logic       ref_pulse;
  logic       ab_done;   // all-bank side outputs
  logic [7:0] ab_idle;
  bank_t      ab_cnt;
  int         fail_count;
  int         comparisons;
  refsched_if link_pb ();
  refsched_if link_ab ();
  refsched_ctrl #(.REFI_CYC(50), .USE_PER_BANK(1'b1)) i_refsched_ctrl (
    .CORE_CLK(clk), .RESET(rst), .ACT_REQ(act_req), .ACT_BANK(act_bank),
    .PRE_REQ(pre_req), .PRE_BANK(pre_bank), .PREA_REQ(prea_req),
    .SRX_REQ(srx_req), .ACT_DONE(act_done), .REF_DONE(ref_done),
    .BANK_OPEN(bank_open), .NEXT_REF_BANK(next_bank), .link(link_pb));
  refsched_mem i_refsched_mem (.CORE_CLK(clk), .RESET(rst), .link(link_pb),
    .BANK_BUSY(bank_busy), .BANK_IDLE(bank_idle), .REF_BANK_CNT(dev_cnt),
    .REF_PULSE(ref_pulse));
  refsched_ctrl #(.REFI_CYC(50), .USE_PER_BANK(1'b0)) i_refsched_ctrl_ab (
    .CORE_CLK(clk), .RESET(rst), .ACT_REQ(act_req), .ACT_BANK(act_bank),
    .PRE_REQ(pre_req), .PRE_BANK(pre_bank), .PREA_REQ(prea_req),
    .SRX_REQ(srx_req), .ACT_DONE(), .REF_DONE(ab_done), .BANK_OPEN(),
    .NEXT_REF_BANK(), .link(link_ab));
  refsched_mem i_refsched_mem_ab (.CORE_CLK(clk), .RESET(rst),
    .link(link_ab), .BANK_BUSY(), .BANK_IDLE(ab_idle),
    .REF_BANK_CNT(ab_cnt), .REF_PULSE());
  refsched_sva i_sva_pb (.CORE_CLK(clk), .RESET(rst), .cs_n(link_pb.cs_n),
    .ca(link_pb.ca), .ba(link_pb.ba), .aux(link_pb.aux));
  refsched_sva i_sva_ab (.CORE_CLK(clk), .RESET(rst), .cs_n(link_ab.cs_n),
    .ca(link_ab.ca), .ba(link_ab.ba), .aux(link_ab.aux));
  // compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // wait for a per-bank refresh, bounded
  task automatic wait_ref();
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (ref_done !== 1'b1 && n < 200);
    check(8'(ref_done), 8'h1);
    @(negedge clk);
    check(8'(ref_pulse), 8'h1);
  endtask
  // activate, then close by one-bank or all-bank precharge
  task automatic do_act(input bank_t b, input bit all, inout int k);
    @(posedge clk);
    act_req  <= 1'b1;
    act_bank <= b;
    do begin @(negedge clk); k++; end while (act_done !== 1'b1 && k < 200);
    check(8'(act_done), 8'h1);
    @(posedge clk);
    act_req <= 1'b0;
    @(negedge clk);
    check(bank_open, 8'h1 << b);
    @(posedge clk);
    prea_req <= all;
    pre_req  <= !all;
    pre_bank <= b;
    @(posedge clk);
    prea_req <= 1'b0;
    pre_req  <= 1'b0;
    repeat (4) @(negedge clk);
    check(bank_idle, 8'hff);
  endtask
  // idle state after reset
  task automatic reset_values();
    check(bank_open, 8'h0);
    check(bank_idle, 8'hff);
    check(8'(dev_cnt), 8'h0);
    check(8'(link_pb.cs_n), 8'h1);
  endtask
  // nine refreshes wrap the counter; activates beside them
  task automatic per_bank_round();
    int k;
    logic [7:0] exp_busy;
    for (int i = 0; i < 9; i++) begin
      wait_ref();
      k = 1;
      if (i == 3) begin
        do_act(bank_t'(i + 3), 1'b0, k);
        check(8'(k <= 5), 8'h1);
      end
      if (i == 5) begin
        do_act(bank_t'(i), 1'b1, k);
        check(8'(k >= 6), 8'h1);
      end
      repeat (2) @(negedge clk);
      check(8'(dev_cnt), 8'((i + 1) % 8));
      check(8'(next_bank), 8'((i + 1) % 8));
      // only the refreshed bank is held; a long activate outlasts tRFCpb
      exp_busy = (i == 3 || i == 5) ? 8'h00 : 8'h01 << (i % 8);
      check(bank_busy, exp_busy);
    end
  endtask
  // all-bank refresh busies every bank, then frees them
  task automatic all_bank_round();
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (ab_done !== 1'b1 && n < 200);
    check(8'(ab_done), 8'h1);
    // ninth refab held until the first is 32 x tRFCab old
    check(8'(n), 8'h0e);
    repeat (2) @(negedge clk);
    check(ab_idle, 8'h0);
    check(8'(ab_cnt), 8'h0);
    repeat (14) @(negedge clk);
    check(ab_idle, 8'hff);
  endtask
  // self refresh exit zeroes both counters
  task automatic srx_sync();
    wait_ref();
    @(posedge clk);
    srx_req <= 1'b1;
    @(posedge clk);
    srx_req <= 1'b0;
    repeat (4) @(negedge clk);
    check(8'(next_bank), 8'h0);
    check(8'(dev_cnt), 8'h0);
  endtask
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog for a hung wait
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    {act_req, pre_req, prea_req, srx_req} = 4'h0;
    act_bank = 3'h0;
    pre_bank = 3'h0;
    fail_count = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    reset_values();
    per_bank_round();
    all_bank_round();
    srx_sync();
    complete_run();
  end
endmodule

// ---- common/refsched_cfg.svh ----
// timing and encoding constants for the refresh scheduling link
`ifndef REFSCHED_CFG_SVH
`define REFSCHED_CFG_SVH
`define CLK_PERIOD_PS   10000
`define T_RFCAB_PS      130000
`define T_RFCPB_PS      60000
`define T_RRD_PS        10000
`define T_RP_PS         18000
`define T_REFI_PS       7800000
`define CYC_RFCAB ((`T_RFCAB_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_RFCPB ((`T_RFCPB_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_RRD   ((`T_RRD_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_RP    ((`T_RP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_REFI  (`T_REFI_PS / `CLK_PERIOD_PS)
`define BURST_MAX_REFAB 8
`define REFBW_FACTOR    32
`define CA_REF_CODE     3'h4
`endif

// ---- common/refsched_if.sv ----
// command link between controller and memory end
`timescale 1ns/1ps
interface refsched_if;
  logic       cs_n;     // chip select, active low
  logic [3:0] ca;       // command bits ca0..ca3
  logic [2:0] ba;       // bank for activate or precharge
  logic [2:0] aux;      // 0 act, 1 pre, 2 prea, 3 reset, 4 srx, 7 none
  modport ctrl (output cs_n, output ca, output ba, output aux);
  modport mem  (input cs_n, input ca, input ba, input aux);
endinterface

// ---- common/refsched_pkg.sv ----
// types shared by both ends of the refresh link
package refsched_pkg;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_PRE, CMD_PREA, CMD_REFPB, CMD_REFAB, CMD_RESET,
    CMD_SRX
  } cmd_t;
  typedef logic [2:0] bank_t;
endpackage

// ---- hw/refsched_ctrl.sv ----
// refresh scheduling controller end
`timescale 1ns/1ps
`include "refsched_cfg.svh"
// Function
// - wait tRRD after activate before refpb
// - other banks usable during per-bank refresh
// - refreshed bank idle after refpb
// - tRFCpb after refpb before refresh or same-bank act
// - other-bank activate after refpb needs tRRD only
// - refab only with all banks idle
// - refab zeroes bank counter both ends
// - refab waits tRFCab, tRFCpb and tRP
// - all banks idle after refab
// - tRFCab after refab before act or refresh
// - never refresh an open bank
// - one refresh per tREFI distributed pattern
// - pause bounded by tREFW minus R*4*tRFCab
// - minimum count holds in every rolling window
// - self refresh counts as distributed refresh
// - at least R refab per 32 ms window
// - eight refpb may replace one refab
// - at most eight refab per tREFBW
// - self refresh time reduces required count
// - refresh encoding cs low, ca 0-0-1, ca3 type
// - bank counter round robin 0 to 7
// - counter zeroed on reset and self refresh exit
// - refpb waits tRFCab, tRFCpb, tRP of bank
module refsched_ctrl
  import refsched_pkg::*;
#(
  parameter int REFI_CYC = `CYC_REFI,
  parameter bit USE_PER_BANK = 1'b1
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  input  wire logic       ACT_REQ,
  input  wire logic [2:0] ACT_BANK,
  input  wire logic       PRE_REQ,
  input  wire logic [2:0] PRE_BANK,
  input  wire logic       PREA_REQ,
  input  wire logic       SRX_REQ,
  output logic            ACT_DONE,
  output logic            REF_DONE,
  output logic [7:0]      BANK_OPEN,
  output logic [2:0]      NEXT_REF_BANK,
  refsched_if.ctrl        link
);
  localparam int CW = 16;              // timer width
  logic [CW-1:0] refi_r;                // distributed refresh interval timer
  logic [CW-1:0] rfc_r;                 // global refresh blocking timer
  logic [CW-1:0] rrd_r;                 // activate to activate/refpb timer
  logic [CW-1:0] rp_r [8];              // per-bank precharge timers
  logic [CW-1:0] rfpb_r [8];            // per-bank refpb blocking timers
  logic [CW-1:0] ab_age_r [`BURST_MAX_REFAB]; // ages of recent refab
  logic [2:0]    bank_r;                // local copy of device bank counter
  logic [7:0]    open_r;                // open bank map
  logic          pending_r;             // a refresh is owed
  cmd_t          cmd;                   // command chosen this cycle
  logic          all_rp_ok;             // all precharge timers done
  logic          ref_ok;                // refresh may go this cycle

  // precharge timers all expired
  always_comb begin
    all_rp_ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (rp_r[i] != '0) all_rp_ok = 1'b0;
    end
  end

  // refresh legality; refpb path refreshes only an idle, settled bank
  always_comb begin
    if (USE_PER_BANK) begin
      ref_ok = (rfc_r == '0) && (rrd_r == '0) &&
               !open_r[bank_r] && (rp_r[bank_r] == '0) &&
               (rfpb_r[0] == '0) && (rfpb_r[1] == '0) &&
               (rfpb_r[2] == '0) && (rfpb_r[3] == '0) &&
               (rfpb_r[4] == '0) && (rfpb_r[5] == '0) &&
               (rfpb_r[6] == '0) && (rfpb_r[7] == '0);
    end else begin
      ref_ok = (rfc_r == '0) && (open_r == 8'h00) && all_rp_ok &&
               (ab_age_r[`BURST_MAX_REFAB - 1] >=
                CW'(`REFBW_FACTOR * `CYC_RFCAB)) &&
               (rfpb_r[0] == '0) && (rfpb_r[1] == '0) &&
               (rfpb_r[2] == '0) && (rfpb_r[3] == '0) &&
               (rfpb_r[4] == '0) && (rfpb_r[5] == '0) &&
               (rfpb_r[6] == '0) && (rfpb_r[7] == '0);
    end
  end

  // command arbitration: self refresh exit first, then owed refresh, then user requests
  always_comb begin
    cmd = CMD_NOP;
    if (SRX_REQ) begin
      cmd = CMD_SRX;
    end else if (pending_r && ref_ok) begin
      cmd = USE_PER_BANK ? CMD_REFPB : CMD_REFAB;
    end else if (PREA_REQ) begin
      cmd = CMD_PREA;
    end else if (PRE_REQ) begin
      cmd = CMD_PRE;
    end else if (ACT_REQ && !open_r[ACT_BANK] && rfc_r == '0 &&
                 rrd_r == '0 && rp_r[ACT_BANK] == '0 &&
                 rfpb_r[ACT_BANK] == '0 &&
                 !(pending_r && !USE_PER_BANK)) begin
      cmd = CMD_ACT;
    end
  end

  // distributed refresh tick, one owed refresh per interval; an even
  // pattern keeps every rolling window full and allows self refresh
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      refi_r    <= '0;
      pending_r <= 1'b0;
    end else begin
      if (refi_r == CW'(REFI_CYC - 1)) begin
        refi_r    <= '0;
        pending_r <= 1'b1;
      end else begin
        refi_r <= refi_r + 1'b1;
        if (cmd == CMD_REFPB || cmd == CMD_REFAB) pending_r <= 1'b0;
      end
    end
  end

  // global timers, rounded-up cycle counts
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rfc_r <= '0;
      rrd_r <= '0;
    end else begin
      if (cmd == CMD_REFAB) rfc_r <= CW'(`CYC_RFCAB);
      else if (rfc_r != '0) rfc_r <= rfc_r - 1'b1;
      if (cmd == CMD_ACT || cmd == CMD_REFPB) rrd_r <= CW'(`CYC_RRD);
      else if (rrd_r != '0) rrd_r <= rrd_r - 1'b1;
    end
  end

  // per-bank precharge and refpb timers, open map
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bank
      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          rp_r[g]   <= '0;
          rfpb_r[g] <= '0;
          open_r[g] <= 1'b0;
        end else begin
          if (cmd == CMD_PREA || (cmd == CMD_PRE && PRE_BANK == 3'(g))) begin
            rp_r[g]   <= CW'(`CYC_RP);
            open_r[g] <= 1'b0;
          end else begin
            if (rp_r[g] != '0) rp_r[g] <= rp_r[g] - 1'b1;
            if (cmd == CMD_ACT && ACT_BANK == 3'(g)) open_r[g] <= 1'b1;
          end
          if (cmd == CMD_REFPB && bank_r == 3'(g)) begin
            rfpb_r[g] <= CW'(`CYC_RFCPB);
          end else if (rfpb_r[g] != '0) begin
            rfpb_r[g] <= rfpb_r[g] - 1'b1;
          end
        end
      end
    end
  endgenerate

  // bank counter copy: step on refpb, zero on refab or exit
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      bank_r <= '0;
    end else if (cmd == CMD_REFAB || cmd == CMD_SRX) begin
      bank_r <= '0;
    end else if (cmd == CMD_REFPB) begin
      bank_r <= bank_r + 1'b1;
    end
  end

  // rolling burst limit: saturating ages of the last eight refab, newest
  // first; a fixed window would let sixteen cluster across its boundary
  generate
    for (genvar h = 0; h < `BURST_MAX_REFAB; h++) begin : g_age
      localparam int prev_idx = (h == 0) ? 0 : h - 1;  // younger neighbour
      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          ab_age_r[h] <= '1;                         // as if long ago
        end else if (cmd == CMD_REFAB && h == 0) begin
          ab_age_r[h] <= '0;
        end else if (cmd == CMD_REFAB) begin
          ab_age_r[h] <= (ab_age_r[prev_idx] == '1) ? '1 :
                         ab_age_r[prev_idx] + 1'b1;  // shift one older
        end else if (ab_age_r[h] != '1) begin
          ab_age_r[h] <= ab_age_r[h] + 1'b1;         // saturating age
        end
      end
    end
  endgenerate

  // drive link pins from flip-flops
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      link.cs_n <= 1'b1;
      link.ca   <= 4'h0;
      link.ba   <= 3'h0;
      link.aux  <= 3'h7;
    end else begin
      link.cs_n <= (cmd == CMD_NOP);
      link.ca   <= 4'h0;
      link.ba   <= (cmd == CMD_PRE) ? PRE_BANK : ACT_BANK;
      link.aux  <= 3'h7;
      case (cmd)
        CMD_REFPB: link.ca <= {1'b0, `CA_REF_CODE};
        CMD_REFAB: link.ca <= {1'b1, `CA_REF_CODE};
        CMD_ACT:   link.aux <= 3'h0;
        CMD_PRE:   link.aux <= 3'h1;
        CMD_PREA:  link.aux <= 3'h2;
        CMD_SRX:   link.aux <= 3'h4;
        default:   link.aux <= 3'h7;
      endcase
    end
  end

  // user status outputs
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ACT_DONE      <= 1'b0;
      REF_DONE      <= 1'b0;
      BANK_OPEN     <= 8'h00;
      NEXT_REF_BANK <= 3'h0;
    end else begin
      ACT_DONE      <= (cmd == CMD_ACT);
      REF_DONE      <= (cmd == CMD_REFPB || cmd == CMD_REFAB);
      BANK_OPEN     <= open_r;
      NEXT_REF_BANK <= bank_r;
    end
  end
endmodule

// ---- hw/refsched_mem.sv ----
// memory end: decodes refresh commands and tracks bank state
`timescale 1ns/1ps
`include "refsched_cfg.svh"
module refsched_mem
  import refsched_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  refsched_if.mem         link,
  output logic [7:0]      BANK_BUSY,
  output logic [7:0]      BANK_IDLE,
  output logic [2:0]      REF_BANK_CNT,
  output logic            REF_PULSE
);
  logic [15:0] busy_r [8];       // per-bank refresh remaining cycles
  logic [7:0]  open_r;           // open bank map
  logic [2:0]  cnt_r;            // per-bank refresh counter
  logic        is_ref;           // refresh command decoded
  logic        is_refab;         // all-bank form

  // decode refresh: cs low and ca0..2 = 0,0,1
  always_comb begin
    is_ref   = !link.cs_n && (link.ca[2:0] == `CA_REF_CODE);
    is_refab = is_ref && link.ca[3];
  end

  // per-bank busy timers; refpb holds only the target bank, refab holds all
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bank
      always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
          busy_r[g] <= '0;
          open_r[g] <= 1'b0;
        end else begin
          if (is_refab) begin
            busy_r[g] <= 16'(`CYC_RFCAB);
            open_r[g] <= 1'b0;
          end else if (is_ref && cnt_r == 3'(g)) begin
            busy_r[g] <= 16'(`CYC_RFCPB);
            open_r[g] <= 1'b0;
          end else begin
            if (busy_r[g] != '0) busy_r[g] <= busy_r[g] - 1'b1;
            if (!link.cs_n && link.aux == 3'h2) open_r[g] <= 1'b0;
            if (!link.cs_n && link.aux == 3'h1 && link.ba == 3'(g))
              open_r[g] <= 1'b0;
            if (!link.cs_n && link.aux == 3'h0 && link.ba == 3'(g))
              open_r[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // bank counter: round robin, zero on refab, reset, exit
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cnt_r <= '0;
    end else if (is_refab || (!link.cs_n &&
                 (link.aux == 3'h3 || link.aux == 3'h4))) begin
      cnt_r <= '0;
    end else if (is_ref) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // registered status outputs
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      BANK_BUSY    <= 8'h00;
      BANK_IDLE    <= 8'hff;
      REF_BANK_CNT <= 3'h0;
      REF_PULSE    <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        BANK_BUSY[i] <= (busy_r[i] != '0);
        BANK_IDLE[i] <= !open_r[i] && (busy_r[i] == '0);
      end
      REF_BANK_CNT <= cnt_r;
      REF_PULSE    <= is_ref;
    end
  end
endmodule
